// >>> core/viterbi_pkg.sv
package viterbi_pkg;
   // datapath widths
   localparam int WORD_W = 16; // support word and auxiliary registers
   localparam int ACC_W = 40; // accumulator operands
   localparam int AXI_ADDR_W = 4; // byte address bits decoded
   localparam int AXI_DATA_W = 32; // bus data width

   // register byte offsets
   localparam logic [AXI_ADDR_W-1:0] SUPPORT_OFFSET = 4'h0; // support word
   localparam logic [AXI_ADDR_W-1:0] AUX_FIRST_OFFSET = 4'h4; // first auxiliary register
   localparam logic [AXI_ADDR_W-1:0] AUX_SECOND_OFFSET = 4'h8; // second auxiliary register

   // support word field positions
   localparam int SIDE_EFFECT_BIT = 5; // side_effect_enable
   localparam int SELECT_MAX_BIT = 4; // 1 selects the larger operand
   localparam int TWO_BIT_TB_BIT = 3; // two_bit_traceback
   localparam int OLDER_FLAG_BIT = 1; // older_history_flag
   localparam int NEWER_FLAG_BIT = 0; // newer_history_flag

   // reserved bits 15..6 and 2 always hold zero
   localparam logic [WORD_W-1:0] SUPPORT_WRITE_MASK = 16'h003B;
   localparam logic [WORD_W-1:0] SUPPORT_RESET = 16'h0000; // reset value
   localparam logic [WORD_W-1:0] AUX_RESET = 16'h0000; // auxiliary reset value

   // bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // compare functions issued by the decoder
   typedef enum logic [1:0] {
      CMP_ZEROTH,
      CMP_FIRST,
      CMP_THREE,
      CMP_NONE
   } cmp_func_t;
endpackage

// >>> core/compare_select_unit.sv
`timescale 1ns/1ps
module compare_select_unit (
   input wire logic [viterbi_pkg::ACC_W-1:0] src_operand, // source accumulator
   input wire logic [viterbi_pkg::ACC_W-1:0] dst_operand, // destination accumulator
   input wire logic select_max, // 1 picks the larger operand
   output logic [viterbi_pkg::ACC_W-1:0] selected, // chosen operand
   output logic result_flag // compare_result_flag
);
   import viterbi_pkg::*;

   logic src_below; // signed source below destination

   // flag is 0 when the destination wins, so the flag alone picks the operand
   always_comb begin
      src_below = $signed(src_operand) < $signed(dst_operand);
      result_flag = select_max ? ~src_below : src_below;
      selected = result_flag ? src_operand : dst_operand;
   end
endmodule // compare_select_unit

// >>> core/viterbi_compare_select_support.sv
// Operation
// - enable bit gates all side effects
// - select bit picks minimum or maximum
// - one-bit traceback stuffing into auxiliary registers
// - two-bit mode moves two bits instead
// - three-operand compare shifts newer into older
// - three-operand compare loads newer with result
// - result flag set by operand order
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module viterbi_compare_select_support (
   input wire logic core_clk, // core clock, 100 MHz
   input wire logic rst_n, // asynchronous reset, active low
   input wire logic cmp_valid, // compare issued this cycle
   input wire viterbi_pkg::cmp_func_t cmp_func, // which compare function
   input wire logic [viterbi_pkg::ACC_W-1:0] cmp_src, // source_accumulator
   input wire logic [viterbi_pkg::ACC_W-1:0] cmp_dst, // destination_accumulator
   output logic result_valid, // one-cycle pulse with result
   output logic [viterbi_pkg::ACC_W-1:0] result_data, // selected operand
   output logic result_flag, // compare_result_flag of that compare
   input wire logic [viterbi_pkg::AXI_ADDR_W-1:0] s_axi_awaddr, // write address
   input wire logic s_axi_awvalid, // write address valid
   output logic s_axi_awready, // write address ready
   input wire logic [viterbi_pkg::AXI_DATA_W-1:0] s_axi_wdata, // write data
   input wire logic [3:0] s_axi_wstrb, // write byte enables
   input wire logic s_axi_wvalid, // write data valid
   output logic s_axi_wready, // write data ready
   output logic [1:0] s_axi_bresp, // write response
   output logic s_axi_bvalid, // write response valid
   input wire logic s_axi_bready, // write response ready
   input wire logic [viterbi_pkg::AXI_ADDR_W-1:0] s_axi_araddr, // read address
   input wire logic s_axi_arvalid, // read address valid
   output logic s_axi_arready, // read address ready
   output logic [viterbi_pkg::AXI_DATA_W-1:0] s_axi_rdata, // read data
   output logic [1:0] s_axi_rresp, // read response
   output logic s_axi_rvalid, // read data valid
   input wire logic s_axi_rready // read data ready
);
   import viterbi_pkg::*;

   // architectural state
   logic [WORD_W-1:0] support_word, next_support_word; // viterbi_support_word
   logic [WORD_W-1:0] aux_first, next_aux_first; // aux_reg_first
   logic [WORD_W-1:0] aux_second, next_aux_second; // aux_reg_second
   // registered compare result
   logic next_result_valid, next_result_flag;
   logic [ACC_W-1:0] next_result_data;
   // write channel holding
   logic aw_held, next_aw_held; // address captured
   logic [AXI_ADDR_W-1:0] aw_addr, next_aw_addr;
   logic w_held, next_w_held; // data captured
   logic [AXI_DATA_W-1:0] w_data, next_w_data;
   logic [3:0] w_strb, next_w_strb;
   logic next_bvalid;
   logic [1:0] next_bresp;
   // read channel
   logic next_rvalid;
   logic [1:0] next_rresp;
   logic [AXI_DATA_W-1:0] next_rdata;
   // compare datapath
   logic [ACC_W-1:0] cmp_selected; // combinational choice
   logic cmp_flag; // combinational flag
   logic side_effects_on; // enable bit
   logic two_bit_mode; // traceback width
   logic do_write; // both write halves present, response free

   // byte-lane merge, low two lanes carry the 16-bit registers
   function automatic logic [WORD_W-1:0] merge_lanes(input logic [WORD_W-1:0] old,
         input logic [AXI_DATA_W-1:0] data, input logic [3:0] strb);
      logic [WORD_W-1:0] merged;
      merged = old;
      if (strb[0]) begin
         merged[7:0] = data[7:0];
      end
      if (strb[1]) begin
         merged[15:8] = data[15:8];
      end
      return merged;
   endfunction

   // aligned offsets that hold a register
   function automatic logic is_mapped(input logic [AXI_ADDR_W-1:0] addr);
      return (addr == SUPPORT_OFFSET) || (addr == AUX_FIRST_OFFSET) ||
         (addr == AUX_SECOND_OFFSET);
   endfunction

   compare_select_unit u_cmp (
      .src_operand(cmp_src),
      .dst_operand(cmp_dst),
      .select_max(support_word[SELECT_MAX_BIT]),
      .selected(cmp_selected),
      .result_flag(cmp_flag)
   );

   assign side_effects_on = support_word[SIDE_EFFECT_BIT];
   assign two_bit_mode = support_word[TWO_BIT_TB_BIT];
   assign do_write = aw_held && w_held && !s_axi_bvalid;
   // handshake readies come straight from holding state
   assign s_axi_awready = !aw_held;
   assign s_axi_wready = !w_held;
   assign s_axi_arready = !s_axi_rvalid;

   // support word and auxiliary registers; hardware updates win over a
   // software write in the same cycle so no traceback bit is lost
   always_comb begin
      next_support_word = support_word;
      next_aux_first = aux_first;
      next_aux_second = aux_second;
      if (do_write && aw_addr == SUPPORT_OFFSET) begin
         next_support_word = merge_lanes(support_word, w_data, w_strb) & SUPPORT_WRITE_MASK;
      end
      if (do_write && aw_addr == AUX_FIRST_OFFSET) begin
         next_aux_first = merge_lanes(aux_first, w_data, w_strb);
      end
      if (do_write && aw_addr == AUX_SECOND_OFFSET) begin
         next_aux_second = merge_lanes(aux_second, w_data, w_strb);
      end
      if (cmp_valid && side_effects_on) begin
         case (cmp_func)
            CMP_THREE: begin
               next_support_word[OLDER_FLAG_BIT] = support_word[NEWER_FLAG_BIT];
               next_support_word[NEWER_FLAG_BIT] = cmp_flag;
            end
            CMP_FIRST: begin
               if (two_bit_mode) begin
                  next_aux_first = {aux_first[WORD_W-3:0], support_word[NEWER_FLAG_BIT], cmp_flag};
               end else begin
                  next_aux_first = {aux_first[WORD_W-2:0], cmp_flag};
               end
            end
            CMP_ZEROTH: begin
               if (two_bit_mode) begin
                  next_aux_second = {aux_second[WORD_W-3:0], aux_first[WORD_W-1:WORD_W-2]};
               end else begin
                  next_aux_second = {aux_second[WORD_W-2:0], aux_first[WORD_W-1]};
               end
            end
            default: begin
               // no side effect for an idle code
            end
         endcase
      end
   end

   // compare result register, one cycle after issue
   always_comb begin
      next_result_valid = cmp_valid;
      next_result_data = cmp_valid ? cmp_selected : result_data;
      next_result_flag = cmp_valid ? cmp_flag : result_flag;
   end

   // write channels: address and data taken in either order
   always_comb begin
      next_aw_held = aw_held;
      next_aw_addr = aw_addr;
      next_w_held = w_held;
      next_w_data = w_data;
      next_w_strb = w_strb;
      next_bvalid = s_axi_bvalid;
      next_bresp = s_axi_bresp;
      if (s_axi_awvalid && !aw_held) begin
         next_aw_held = 1'b1;
         next_aw_addr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held) begin
         next_w_held = 1'b1;
         next_w_data = s_axi_wdata;
         next_w_strb = s_axi_wstrb;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         next_bvalid = 1'b0;
      end
      if (do_write) begin
         // unmapped offsets store nothing and report an error
         next_aw_held = 1'b0;
         next_w_held = 1'b0;
         next_bvalid = 1'b1;
         next_bresp = is_mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
      end
   end

   // read channel: data sampled when the address is taken
   always_comb begin
      next_rvalid = s_axi_rvalid;
      next_rdata = s_axi_rdata;
      next_rresp = s_axi_rresp;
      if (s_axi_rvalid && s_axi_rready) begin
         next_rvalid = 1'b0;
      end
      if (s_axi_arvalid && !s_axi_rvalid) begin
         next_rvalid = 1'b1;
         next_rresp = is_mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
         case (s_axi_araddr)
            SUPPORT_OFFSET: next_rdata = AXI_DATA_W'(support_word);
            AUX_FIRST_OFFSET: next_rdata = AXI_DATA_W'(aux_first);
            AUX_SECOND_OFFSET: next_rdata = AXI_DATA_W'(aux_second);
            default: next_rdata = '0;
         endcase
      end
   end

   // all state registers
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         support_word <= SUPPORT_RESET;
         aux_first <= AUX_RESET;
         aux_second <= AUX_RESET;
         result_valid <= 1'b0;
         result_data <= '0;
         result_flag <= 1'b0;
         aw_held <= 1'b0;
         aw_addr <= '0;
         w_held <= 1'b0;
         w_data <= '0;
         w_strb <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
      end else begin
         support_word <= next_support_word;
         aux_first <= next_aux_first;
         aux_second <= next_aux_second;
         result_valid <= next_result_valid;
         result_data <= next_result_data;
         result_flag <= next_result_flag;
         aw_held <= next_aw_held;
         aw_addr <= next_aw_addr;
         w_held <= next_w_held;
         w_data <= next_w_data;
         w_strb <= next_w_strb;
         s_axi_bvalid <= next_bvalid;
         s_axi_bresp <= next_bresp;
         s_axi_rvalid <= next_rvalid;
         s_axi_rdata <= next_rdata;
         s_axi_rresp <= next_rresp;
      end
   end

   // helper slices so the checks below compare whole signals
   logic [WORD_W-2:0] first_low15; // aux_first without msb
   logic [WORD_W-3:0] second_low14; // aux_second without two msbs
   logic [1:0] first_top2; // two msbs of aux_first
   logic newer_flag; // newer history flag alone
   assign first_low15 = aux_first[WORD_W-2:0];
   assign second_low14 = aux_second[WORD_W-3:0];
   assign first_top2 = aux_first[WORD_W-1:WORD_W-2];
   assign newer_flag = support_word[NEWER_FLAG_BIT];

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);

   sequence three_cmp_on_s;
      cmp_valid && cmp_func == CMP_THREE && side_effects_on;
   endsequence
   sequence quiet_cmp_off_s;
      cmp_valid && !side_effects_on && !do_write;
   endsequence

   history_newer_a: assert property (three_cmp_on_s |=> newer_flag == $past(cmp_flag))
      else $error("newer history flag not loaded from compare");
   history_older_a: assert property (three_cmp_on_s |=>
      support_word[OLDER_FLAG_BIT] == $past(newer_flag))
      else $error("older history flag not loaded from newer");
   disabled_hold_a: assert property (quiet_cmp_off_s |=>
      $stable(aux_first) && $stable(aux_second) && $stable(support_word))
      else $error("state changed while side effects disabled");
   select_min_a: assert property (cmp_valid && !support_word[SELECT_MAX_BIT] |=>
      result_valid && ($signed(result_data) <= $signed($past(cmp_src))) &&
      ($signed(result_data) <= $signed($past(cmp_dst))))
      else $error("minimum not selected");
   max_flag_a: assert property (cmp_valid && support_word[SELECT_MAX_BIT] &&
      $signed(cmp_src) < $signed(cmp_dst) |=> !result_flag && result_data == $past(cmp_dst))
      else $error("maximum compare flag or selection wrong");
   one_bit_stuff_a: assert property (cmp_valid && side_effects_on &&
      cmp_func == CMP_FIRST && !two_bit_mode && !do_write |=>
      aux_first == {$past(first_low15), $past(cmp_flag)})
      else $error("one-bit traceback stuffing wrong");
   two_bit_move_a: assert property (cmp_valid && side_effects_on &&
      cmp_func == CMP_ZEROTH && two_bit_mode && !do_write |=>
      aux_second == {$past(second_low14), $past(first_top2)})
      else $error("two-bit traceback move wrong");
   enable_gate_a: assert property (cmp_valid && !side_effects_on && !do_write &&
      cmp_func == CMP_THREE |=> $stable(support_word))
      else $error("history changed with side effects off");
   write_resp_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
      s_axi_wready |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before ready");
endmodule // viterbi_compare_select_support

// >>> tb/cmp_issuer.sv
`timescale 1ns/1ps
module cmp_issuer (
   input wire logic core_clk, // core clock
   input wire logic rst_n, // reset, active low
   input wire logic issue, // bench asks for one compare
   input wire viterbi_pkg::cmp_func_t func_in, // function to issue
   input wire logic [viterbi_pkg::ACC_W-1:0] src_in, // source operand to issue
   input wire logic [viterbi_pkg::ACC_W-1:0] dst_in, // destination operand to issue
   output logic cmp_valid, // compare issued this cycle
   output viterbi_pkg::cmp_func_t cmp_func, // function lines
   output logic [viterbi_pkg::ACC_W-1:0] cmp_src, // source operand lines
   output logic [viterbi_pkg::ACC_W-1:0] cmp_dst // destination operand lines
);
   import viterbi_pkg::*;
   // decoder issue stage, one compare a cycle at most; gaps come from the bench
   // idle cycles churn the lines so a stale operand never passes for a fresh one
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         cmp_valid <= 1'b0;
         cmp_func <= CMP_NONE;
         cmp_src <= '0;
         cmp_dst <= '0;
      end else if (issue) begin
         cmp_valid <= 1'b1;
         cmp_func <= func_in;
         cmp_src <= src_in;
         cmp_dst <= dst_in;
      end else begin
         cmp_valid <= 1'b0;
         cmp_func <= cmp_func_t'(cmp_func + 2'h1);
         cmp_src <= ~cmp_src;
         cmp_dst <= ~cmp_dst;
      end
   end
endmodule // cmp_issuer

// >>> tb/tb_viterbi_compare_select_support.sv
`timescale 1ns/1ps
module tb_viterbi_compare_select_support;
   import viterbi_pkg::*;
   logic core_clk = 1'b0; // core clock
   logic rst_n = 1'b0; // reset, active low
   logic issue = 1'b0; // request to the issuer
   cmp_func_t func_in = CMP_NONE; // function to issue
   logic [ACC_W-1:0] src_in = '0; // source operand to issue
   logic [ACC_W-1:0] dst_in = '0; // destination operand to issue
   logic cmp_valid; // issuer outputs
   cmp_func_t cmp_func;
   logic [ACC_W-1:0] cmp_src;
   logic [ACC_W-1:0] cmp_dst;
   logic result_valid; // design results
   logic [ACC_W-1:0] result_data;
   logic result_flag;
   logic [3:0] awaddr = '0; // bus master signals
   logic awvalid = 1'b0;
   logic [31:0] wdata = '0;
   logic [3:0] wstrb = 4'hF;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic [3:0] araddr = '0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid; // slave answers
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   int fail_count = 0; // mismatches
   int cmp_count = 0; // comparisons made
   int cyc = 0; // cycles since start, for the timeout
   logic [WORD_W-1:0] m_sw = '0; // expected support word
   logic [WORD_W-1:0] m_aux1 = '0; // expected first auxiliary register
   logic [WORD_W-1:0] m_aux2 = '0; // expected second auxiliary register
   logic [ACC_W:0] exp_q[$]; // expected {flag, selected} in issue order

   cmp_issuer u_cmp_issuer (.core_clk(core_clk), .rst_n(rst_n), .issue(issue),
      .func_in(func_in), .src_in(src_in), .dst_in(dst_in), .cmp_valid(cmp_valid),
      .cmp_func(cmp_func), .cmp_src(cmp_src), .cmp_dst(cmp_dst));
   viterbi_compare_select_support u_viterbi_compare_select_support (.core_clk(core_clk),
      .rst_n(rst_n), .cmp_valid(cmp_valid), .cmp_func(cmp_func), .cmp_src(cmp_src),
      .cmp_dst(cmp_dst), .result_valid(result_valid), .result_data(result_data),
      .result_flag(result_flag), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

   initial begin
      forever #5 core_clk = ~core_clk;
   end

   task automatic report_and_stop();
      $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task automatic chk_res(input logic [ACC_W:0] got, input logic [ACC_W:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t result got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t data got %0h exp %0h", $time, got, exp);
      end
   endtask

   task automatic chk_resp(input logic [1:0] got, input logic [1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t resp got %0h exp %0h", $time, got, exp);
      end
   endtask

   // write: address and data offered together, each dropped when taken
   task automatic axi_wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s,
      input logic [1:0] er);
      @(posedge core_clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid === 1'b1) begin
            bready <= 1'b0;
            chk_resp(bresp, er);
            break;
         end
      end
   endtask

   // read and compare data and response
   task automatic rd_chk(input logic [3:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge core_clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge core_clk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid === 1'b1) begin
            rready <= 1'b0;
            chk_reg(rdata, ed);
            chk_resp(rresp, er);
            break;
         end
      end
   endtask

   // signed compare flag: maximum mode flags src at or above dst
   function automatic logic exp_flag(input logic [ACC_W-1:0] s, input logic [ACC_W-1:0] d,
      input logic mx);
      return mx ? ($signed(s) >= $signed(d)) : ($signed(s) < $signed(d));
   endfunction

   // issue one compare and advance the expected side-effect state
   task automatic issue_cmp(input cmp_func_t f, input logic [ACC_W-1:0] s,
      input logic [ACC_W-1:0] d);
      logic fl;
      fl = exp_flag(s, d, m_sw[4]);
      exp_q.push_back({fl, fl ? s : d});
      if (m_sw[5]) begin
         case (f)
            CMP_THREE: m_sw[1:0] = {m_sw[0], fl};
            CMP_FIRST: m_aux1 = m_sw[3] ? {m_aux1[13:0], m_sw[0], fl} : {m_aux1[14:0], fl};
            CMP_ZEROTH: m_aux2 = m_sw[3] ? {m_aux2[13:0], m_aux1[15:14]} :
               {m_aux2[14:0], m_aux1[15]};
            default: ;
         endcase
      end
      issue <= 1'b1;
      func_in <= f;
      src_in <= s;
      dst_in <= d;
      @(posedge core_clk);
   endtask

   // result monitor and timeout; an unexpected result counts as a mismatch
   always @(posedge core_clk) begin
      cyc <= cyc + 1;
      if (rst_n && result_valid === 1'b1) begin
         if (exp_q.size() == 0) begin
            // a result that no compare asked for
            fail_count++;
            $display("[ERR] %0t extra result got %0h exp %0h", $time, result_data, 40'h0);
         end else begin
            chk_res({result_flag, result_data}, exp_q.pop_front());
         end
      end
      // the timeout comes last so nothing runs after the stop
      if (cyc == 20000) begin
         fail_count++;
         report_and_stop();
      end
   end

   initial begin
      logic [15:0] nv;
      logic [3:0] st;
      void'($urandom(32'h2535d25a));
      repeat (4) @(posedge core_clk);
      rst_n <= 1'b1;
      rd_chk(SUPPORT_OFFSET, 32'h0, RESP_OKAY);
      rd_chk(AUX_FIRST_OFFSET, 32'h0, RESP_OKAY);
      rd_chk(AUX_SECOND_OFFSET, 32'h0, RESP_OKAY);
      rd_chk(4'hC, 32'h0, RESP_SLVERR);
      rd_chk(4'h2, 32'h0, RESP_SLVERR);
      axi_wr(4'hC, $urandom(), 4'hF, RESP_SLVERR);
      axi_wr(SUPPORT_OFFSET, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
      rd_chk(SUPPORT_OFFSET, 32'h0000003B, RESP_OKAY);
      // every enable, select and traceback mode, with random history flags
      for (int m = 0; m < 8; m++) begin
         m_sw = 16'(m << 3) | 16'($urandom_range(3));
         nv = 16'($urandom());
         st = 4'($urandom());
         m_aux1 = {st[1] ? nv[15:8] : 8'h00, st[0] ? nv[7:0] : 8'h00};
         m_aux2 = 16'($urandom());
         axi_wr(SUPPORT_OFFSET, {16'h0, m_sw}, 4'hF, RESP_OKAY);
         axi_wr(AUX_FIRST_OFFSET, 32'h0, 4'hF, RESP_OKAY);
         axi_wr(AUX_FIRST_OFFSET, {16'hFFFF, nv}, st, RESP_OKAY);
         axi_wr(AUX_SECOND_OFFSET, {16'h0, m_aux2}, 4'hF, RESP_OKAY);
         issue_cmp(CMP_THREE, 40'h0, 40'h0);
         issue_cmp(CMP_FIRST, 40'h7FFFFFFFFF, 40'h8000000000);
         issue_cmp(CMP_ZEROTH, 40'h8000000000, 40'h7FFFFFFFFF);
         for (int i = 0; i < 14; i++) begin
            if ($urandom_range(3) == 0) begin
               issue <= 1'b0;
               @(posedge core_clk);
            end
            issue_cmp(cmp_func_t'($urandom_range(3)), {8'($urandom()), $urandom()},
               {8'($urandom()), $urandom()});
         end
         issue <= 1'b0;
         for (int i = 0; i < 20 && exp_q.size() != 0; i++) @(posedge core_clk);
         rd_chk(SUPPORT_OFFSET, {16'h0, m_sw}, RESP_OKAY);
         rd_chk(AUX_FIRST_OFFSET, {16'h0, m_aux1}, RESP_OKAY);
         rd_chk(AUX_SECOND_OFFSET, {16'h0, m_aux2}, RESP_OKAY);
      end
      // a compare whose result never arrived counts as a mismatch
      chk_reg(32'(exp_q.size()), 32'h0);
      report_and_stop();
   end
endmodule // tb_viterbi_compare_select_support
